// >>> common/dps_pkg.sv
// Shared constants for the dual potentiometer serial slave
package dps_pkg;
    localparam int          CLK_HZ          = 25_000_000;
    localparam logic [3:0]  ADDR_UPPER      = 4'h5;        // Arbitrary fixed upper address bits
    localparam logic [7:0]  WIPER_POWERUP   = 8'h80;
    localparam int          NV_WRITE_MS     = 20;          // Longest non-volatile write time
    localparam int          NV_WRITE_CYCLES = NV_WRITE_MS * (CLK_HZ / 1000);
    localparam logic [3:0]  BIT_ACK         = 4'h8;
    localparam logic [7:0]  REG_WIPER0      = 8'h00;
    localparam logic [7:0]  REG_WIPER1      = 8'h01;
    typedef enum logic [2:0] {DPS_IDLE, DPS_ADDR, DPS_RX, DPS_TX, DPS_TXACK} dps_state_t;
endpackage

// >>> dv/dps_master.sv
// Two-wire bus master model
module dps_master (output logic scl_lo, sda_lo, input wire logic sda);
    timeunit 1ns; timeprecision 1ns;
    initial {scl_lo, sda_lo} = 2'b00;
    // Lines only pulled low or released
    task automatic bitx(input logic b, output logic r);
        #40 sda_lo = !b;
        #160 scl_lo = 0;
        #80 r = sda;
        #40 scl_lo = 1;
    endtask
    // Long first wait: slave drops its ack first
    task automatic start();
        #280 scl_lo = 0;
        #160 sda_lo = 1;
        #160 scl_lo = 1;
    endtask
    task automatic stop();
        #40 sda_lo = 1;
        #160 scl_lo = 0;
        #160 sda_lo = 0;
    endtask
    task automatic xfer(input logic [7:0] v, input logic a, output logic [7:0] q, output logic k);
        for (int i = 7; i >= 0; i--) bitx(v[i], q[i]);
        bitx(a, k);
    endtask
endmodule

// >>> dv/dps_slave_assertions.sv
// Port checks for the serial slave
module dps_slave_chk #(parameter int NV_CYCLES = 50) (
    input wire logic       mclk, rstn, scl_in, sda_in, sda_out, sda_oe, store_ready, nv_write_busy,
    input wire logic [2:0] address_select_pin, strap_latched,
    input wire logic [7:0] wiper_position_reg0, wiper_tap0
);
    int unsigned run;
    always_ff @(posedge mclk) run <= (rstn && nv_write_busy) ? run + 1 : 0;
    default clocking @(posedge mclk); endclocking
    default disable iff (!rstn);
    drain_only_a: assert property (sda_out == 1'b0) else $error("pin driven");
    oe_on_low_a: assert property ($changed(sda_oe) |-> !$past(scl_in, 2)) else $error("oe moved");
    tap_map_a: assert property (wiper_tap0 == wiper_position_reg0) else $error("tap");
    power_up_a: assert property (disable iff (1'b0) !rstn |=> wiper_position_reg0 == 8'h80 && !sda_oe)
        else $error("reset");
    strap_take_a: assert property ($changed(strap_latched) |-> strap_latched == $past(address_select_pin))
        else $error("strap");
    write_time_a: assert property ($fell(nv_write_busy) |-> run == NV_CYCLES) else $error("busy time");
    stop_starts_a: assert property ($rose(nv_write_busy) |-> scl_in && sda_in && !$past(sda_in, 8))
        else $error("no stop");
    match_only_a: assert property ($changed(wiper_position_reg0) && $past(store_ready, 2)
        |-> strap_latched == address_select_pin) else $error("no match");
    ack_free_a: assert property ($rose(sda_oe) |-> ##[1:100] !sda_oe) else $error("oe stuck");
    cover property ($rose(nv_write_busy));
    cover property ($rose(sda_oe));
    cover property ($changed(strap_latched));
endmodule
bind dps_slave dps_slave_chk #(.NV_CYCLES(NV_CYCLES)) u_chk (.*);

// >>> dv/testbench.sv
// Random and corner traffic through the serial slave
module testbench;
    timeunit 1ns; timeprecision 1ns;
    import dps_pkg::*;
    logic        mclk = 0, rstn = 0, rdy = 0, scl_lo, sda_lo, sda_oe, busy, ack;
    logic [2:0]  strap = 0;
    logic [7:0]  iv0 = 0, w0, w1, q, d, t0, t1;
    logic [31:0] seed = 33;
    int          mismatches = 0, n_checks = 0;
    wire         sda_bus = ~(sda_lo | sda_oe);
    always #20 mclk = ~mclk;
    dps_master u_mst (.scl_lo(scl_lo), .sda_lo(sda_lo), .sda(sda_bus));
    dps_slave #(.NV_CYCLES(50)) u_dut (.mclk(mclk), .rstn(rstn), .scl_in(~scl_lo), .sda_in(sda_bus), .sda_out(),
        .sda_oe(sda_oe), .address_select_pin(strap), .initial_value_store0(iv0), .initial_value_store1(~iv0),
        .store_ready(rdy), .wiper_position_reg0(w0), .wiper_position_reg1(w1), .wiper_tap0(t0), .wiper_tap1(t1),
        .nv_write_busy(busy), .strap_latched());
    function automatic logic [7:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[7:0];
    endfunction
    task automatic finish_test();
        if (mismatches == 0 && n_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        n_checks++;
        mismatches += int'(g !== e);
        if (g !== e) $display("ERROR %s expected %h seen %h", n, e, g);
    endtask
    task automatic wb(input logic [7:0] v, input logic e);
        u_mst.xfer(v, 1'b1, q, ack);
        chk("ack", {7'h0, e}, {7'h0, ack});
    endtask
    initial begin
        repeat (10) @(posedge mclk);
        #1 rstn = 1;
        iv0 = rnd();
        rdy = 1;
        repeat (3) @(posedge mclk);
        #1 chk("load0", iv0, w0);
        chk("load1", ~iv0, w1);
        for (int i = 0; i < 8; i++) begin
            d = (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : rnd();
            strap = i[2:0];
            u_mst.start();
            wb({ADDR_UPPER, strap, 1'b0}, 1'b0);
            wb({7'h0, i[0]}, 1'b0);
            wb(d, 1'b0);
            u_mst.stop();
            repeat (8) @(posedge mclk);
            #1 chk("busy", 8'h01, {7'h0, busy});
            chk("wiper", d, i[0] ? w1 : w0);
            chk("tap", d, i[0] ? t1 : t0);
            // Sample off the edge so the busy flag has settled
            repeat (200) if (busy !== 1'b0) begin
                @(posedge mclk);
                #1;
            end
            chk("idle", 8'h00, {7'h0, busy});
            if (busy !== 1'b0) finish_test();
            u_mst.start();
            wb({ADDR_UPPER, strap, 1'b1}, 1'b0);
            u_mst.xfer(8'hFF, 1'b1, q, ack);
            chk("read", d, q);
            u_mst.stop();
            u_mst.start();
            wb({ADDR_UPPER, ~strap, 1'b0}, 1'b1);
            u_mst.stop();
        end
        finish_test();
    end
endmodule

// >>> rtl/dps_slave.sv
// Two-wire slave front end with address match, wiper registers and write timer
module dps_slave
    import dps_pkg::*;
#(
    parameter int NV_CYCLES = dps_pkg::NV_WRITE_CYCLES
) (
    input  wire logic       mclk,
    input  wire logic       rstn,
    input  wire logic       scl_in,
    input  wire logic       sda_in,
    output logic            sda_out,
    output logic            sda_oe,
    input  wire logic [2:0] address_select_pin,
    input  wire logic [7:0] initial_value_store0,
    input  wire logic [7:0] initial_value_store1,
    input  wire logic       store_ready,
    output logic [7:0]      wiper_position_reg0,
    output logic [7:0]      wiper_position_reg1,
    output logic [7:0]      wiper_tap0,
    output logic [7:0]      wiper_tap1,
    output logic            nv_write_busy,
    output logic [2:0]      strap_latched
);
    import dps_pkg::*;

    logic [2:0] scl_s;
    logic [2:0] sda_s;
    logic       scl;
    logic       sda;
    logic       scl_q;
    logic       sda_q;
    dps_state_t state;
    logic [3:0] bitcnt;
    logic [7:0] shreg;
    logic [7:0] txreg;
    logic       rd_mode;
    logic       drive_low;
    logic [1:0] byte_idx;
    logic [7:0] reg_ptr;
    logic       wrote;
    logic       loaded;
    logic [31:0] nv_cnt;
    logic [2:0] strap_s1;
    logic [2:0] strap_s2;
    logic [2:0] strap_s3;
    logic [2:0] strap_sync;

    // Third stage compared with second filters a single-sample glitch
    wire scl_agree = (scl_s[2] == scl_s[1]);
    wire sda_agree = (sda_s[2] == sda_s[1]);
    wire scl_rise  = scl & ~scl_q;
    wire scl_fall  = ~scl & scl_q;
    wire start_ev  = scl & scl_q & sda_q & ~sda;
    wire stop_ev   = scl & scl_q & ~sda_q & sda;
    wire [7:0] rx_byte  = {shreg[6:0], sda};
    wire [6:0] my_addr  = {ADDR_UPPER, strap_sync};
    wire addr_hit  = (rx_byte[7:1] == my_addr);
    wire [7:0] rd_value = (reg_ptr == REG_WIPER1) ? wiper_position_reg1 : wiper_position_reg0;

    // Tap index equals wiper code: 255 nearest high terminal, 0 nearest low
    assign wiper_tap0    = wiper_position_reg0;
    assign wiper_tap1    = wiper_position_reg1;
    assign sda_out       = 1'b0;
    assign sda_oe        = drive_low;
    assign nv_write_busy = (nv_cnt != 32'h0000_0000);

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            scl_s <= 3'h7;
            sda_s <= 3'h7;
            scl   <= 1'b1;
            sda   <= 1'b1;
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else begin
            scl_s <= {scl_s[1:0], scl_in};
            sda_s <= {sda_s[1:0], sda_in};
            if (scl_agree)
                scl <= scl_s[2];
            if (sda_agree)
                sda <= sda_s[2];
            scl_q <= scl;
            sda_q <= sda;
        end
    end

    // Straps are pins as well: same three-stage agree filter as the bus lines
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            strap_s1   <= 3'h0;
            strap_s2   <= 3'h0;
            strap_s3   <= 3'h0;
            strap_sync <= 3'h0;
        end else begin
            strap_s1 <= address_select_pin;
            strap_s2 <= strap_s1;
            strap_s3 <= strap_s2;
            if (strap_s2 == strap_s3)
                strap_sync <= strap_s3;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            wiper_position_reg0 <= WIPER_POWERUP;
            wiper_position_reg1 <= WIPER_POWERUP;
            loaded              <= 1'b0;
            nv_cnt              <= 32'h0000_0000;
        end else begin
            if (!loaded && store_ready) begin
                wiper_position_reg0 <= initial_value_store0;
                wiper_position_reg1 <= initial_value_store1;
                loaded              <= 1'b1;
            end else if (state == DPS_RX && scl_rise && bitcnt == 4'h7 && byte_idx == 2'h2) begin
                if (reg_ptr == REG_WIPER0)
                    wiper_position_reg0 <= rx_byte;
                else if (reg_ptr == REG_WIPER1)
                    wiper_position_reg1 <= rx_byte;
            end
            if (stop_ev && wrote)
                nv_cnt <= 32'(NV_CYCLES);
            else if (nv_cnt != 32'h0000_0000)
                nv_cnt <= nv_cnt - 32'h0000_0001;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            state         <= DPS_IDLE;
            bitcnt        <= 4'h0;
            shreg         <= 8'h00;
            txreg         <= 8'h00;
            rd_mode       <= 1'b0;
            drive_low     <= 1'b0;
            byte_idx      <= 2'h0;
            reg_ptr       <= REG_WIPER0;
            wrote         <= 1'b0;
            strap_latched <= 3'h0;
        end else if (start_ev || !loaded) begin
            state     <= loaded ? DPS_ADDR : DPS_IDLE;
            bitcnt    <= 4'h0;
            drive_low <= 1'b0;
            byte_idx  <= 2'h0;
        end else if (stop_ev) begin
            state     <= DPS_IDLE;
            drive_low <= 1'b0;
            wrote     <= 1'b0;
        end else begin
            case (state)
                DPS_IDLE: begin
                    drive_low <= 1'b0;
                end
                DPS_ADDR, DPS_RX: begin
                    if (scl_rise && bitcnt < BIT_ACK) begin
                        shreg  <= rx_byte;
                        bitcnt <= bitcnt + 4'h1;
                        if (bitcnt == 4'h7 && state == DPS_ADDR) begin
                            strap_latched <= strap_sync;
                            rd_mode       <= rx_byte[0];
                            if (!addr_hit)
                                state <= DPS_IDLE;
                        end else if (bitcnt == 4'h7) begin
                            if (byte_idx == 2'h1)
                                reg_ptr <= rx_byte;
                            else
                                wrote <= 1'b1;
                        end
                    end else if (scl_fall && bitcnt == BIT_ACK && !drive_low) begin
                        drive_low <= 1'b1;
                    end else if (scl_fall && bitcnt == BIT_ACK) begin
                        drive_low <= 1'b0;
                        bitcnt    <= 4'h0;
                        if (byte_idx != 2'h2)
                            byte_idx <= byte_idx + 2'h1;
                        if (state == DPS_ADDR && rd_mode) begin
                            state     <= DPS_TX;
                            txreg     <= rd_value;
                            drive_low <= ~rd_value[7];
                        end else begin
                            state <= DPS_RX;
                        end
                    end
                end
                DPS_TX: begin
                    if (scl_fall) begin
                        if (bitcnt == 4'h7) begin
                            drive_low <= 1'b0;
                            state     <= DPS_TXACK;
                        end else begin
                            txreg     <= {txreg[6:0], 1'b0};
                            drive_low <= ~txreg[6];
                        end
                        bitcnt <= bitcnt + 4'h1;
                    end
                end
                DPS_TXACK: begin
                    // Master ack continues the read, nack returns to DPS_IDLE at once
                    if (scl_rise) begin
                        if (sda)
                            state <= DPS_IDLE;
                        else
                            reg_ptr <= reg_ptr + 8'h01;
                    end else if (scl_fall) begin
                        state     <= DPS_TX;
                        bitcnt    <= 4'h0;
                        txreg     <= rd_value;
                        drive_low <= ~rd_value[7];
                    end
                end
                default: state <= DPS_IDLE;
            endcase
        end
    end
endmodule
